// ### rtl/reflex_latch_blocks.sv
// Functional notes
// - Analog output holds the captured value while trigger is 1.
// - Analog output follows the analog input while trigger is 0.
// - Analog value is captured at each trigger rise from 0 to 1.
// - Analog path carries a 16-bit word, signed or unsigned.
// - Analog word passes through unchanged without any conversion.
// - Analog trigger selects constant, island, virtual or nested source.
// - Analog operand selects island channel or virtual-module output.
// - Digital latch output is always held, changing only at next edge; here a write of the invert bit also changes it at once.
// - Invert option drives the complement of the captured bit.
// - Enabled by Boolean 1 or constant, disabled by 0 or constant.
// - Disabled block freezes its output while still receiving inputs.
// - On re-enable the block acts at once on latest inputs.
// - Digital enable selects island, virtual or fieldbus bit source.
// - Analog latch shares the same enable and freeze behaviour.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Analog and falling-edge digital latch blocks configured over a register bus.
module reflex_latch_blocks
    import latch_pkg::*;
#(
    parameter int unsigned DATA_W = WORD_W
)
(
    // Clock and reset.
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    // AXI4-Lite write address channel.
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Boolean sources.
    input  wire logic              island_bit_i,
    input  wire logic              virtual_bit_i,
    input  wire logic              fieldbus_bit_i,
    input  wire logic              nested_bit_i,
    // Analog sources.
    input  wire logic [DATA_W-1:0] island_word_i,
    input  wire logic [DATA_W-1:0] virtual_word_i,
    // Block outputs.
    output logic [DATA_W-1:0]      analog_o,
    output logic                   digital_o
);

    // Register file, bus holding registers and the write strobe.
    logic [31:0]       ctrl_reg;
    logic [31:0]       select_reg;
    logic [7:0]        awaddr_reg;
    logic              aw_held_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              w_held_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic              do_write;
    logic [31:0]       status_word;

    // Selected block inputs and the state of both latch variants.
    logic              a_enable;
    logic              a_trigger;
    logic [DATA_W-1:0] a_data;
    logic              d_enable;
    logic              d_trigger;
    logic              d_operand;
    logic              a_trig_prev_reg;
    logic [DATA_W-1:0] a_held_reg;
    logic [DATA_W-1:0] a_out_reg;
    logic              d_held;

    // Boolean source multiplexer shared by every Boolean input.
    // A code that names no source falls back to the constant, so a stray
    // select value never leaves an input undriven. A source that a variant
    // does not offer is passed in as zero and reads as low or disabled.
    function automatic logic pick_bit(input logic [2:0] sel, input logic konst,
                                      input logic isl, input logic virt,
                                      input logic fb, input logic nest);
        logic r;
        r = konst;
        case (sel)
            SRC_ISLAND:   r = isl;
            SRC_VIRTUAL:  r = virt;
            SRC_FIELDBUS: r = fb;
            SRC_NESTED:   r = nest;
            default:      r = konst;
        endcase
        return r;
    endfunction

    // Input selection for both latch variants.
    // All Boolean inputs use the same codes, so one select encoding serves
    // enable, trigger and operand alike. The analog operand has two sources:
    // any code other than the virtual one picks the island channel.
    always_comb begin
        a_enable  = pick_bit(select_reg[SEL_A_EN +: 3], ctrl_reg[CTRL_EN_CONST], island_bit_i,
                             virtual_bit_i, 1'b0, 1'b0);
        a_trigger = pick_bit(select_reg[SEL_A_TRIG +: 3], ctrl_reg[CTRL_TRIG_CONST], island_bit_i,
                             virtual_bit_i, 1'b0, nested_bit_i);
        a_data    = (select_reg[SEL_A_DATA +: 3] == SRC_VIRTUAL) ? virtual_word_i
                                                                 : island_word_i;
        d_enable  = pick_bit(select_reg[SEL_D_EN +: 3], ctrl_reg[CTRL_EN_CONST], island_bit_i,
                             virtual_bit_i, fieldbus_bit_i, 1'b0);
        d_trigger = pick_bit(select_reg[SEL_D_TRIG +: 3], ctrl_reg[CTRL_TRIG_CONST], island_bit_i,
                             virtual_bit_i, fieldbus_bit_i, nested_bit_i);
        d_operand = pick_bit(select_reg[SEL_D_OPER +: 3], ctrl_reg[CTRL_OPER_CONST], island_bit_i,
                             virtual_bit_i, fieldbus_bit_i, nested_bit_i);
    end

    // Analog trigger history, kept while disabled.
    // Tracking the trigger through a disabled spell means that a trigger
    // which is already high at re-enable is not taken for a fresh rise.
    // The register clears to low, the idle level of the constant source.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            a_trig_prev_reg <= 1'b0;
        end else begin
            a_trig_prev_reg <= a_trigger;
        end
    end

    // Analog capture at each rising trigger edge while enabled.
    // A rise seen while disabled is not captured: inputs keep arriving,
    // but the block does not act on them until it is enabled again.
    // Every later rise overwrites the held word with a fresh sample.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            a_held_reg <= '0;
        end else if (a_enable && a_trigger && !a_trig_prev_reg) begin
            a_held_reg <= a_data;
        end
    end

    // Analog output: follow while low, hold while high, freeze while disabled.
    // On the rising edge the output takes the live word, the same word that
    // the capture register takes, so output and held value agree from then on.
    // Re-enabling acts on the present trigger level at once, with no wait for
    // a further change on any input.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            a_out_reg <= '0;
        end else if (a_enable) begin
            if (!a_trigger) begin
                a_out_reg <= a_data;
            end else if (!a_trig_prev_reg) begin
                a_out_reg <= a_data;
            end else begin
                a_out_reg <= a_held_reg;
            end
        end
    end

    assign analog_o = a_out_reg;

    // Falling-edge digital latch.
    // The variant lives in its own module; it shares the select decoding
    // above and takes the invert bit of the control register directly.
    // Its held bit is brought out only for the status word.
    edge_latch u_edge (
        .ref_clk_i  (ref_clk_i),
        .reset_i    (reset_i),
        .enable_i   (d_enable),
        .trigger_i  (d_trigger),
        .operand_i  (d_operand),
        .invert_i   (ctrl_reg[CTRL_INVERT]),
        .latch_o    (digital_o),
        .captured_o (d_held)
    );

    // Write address and data are held independently until both are present.
    // Either may come first; each is parked and its ready drops until the
    // write retires, so a second beat cannot overwrite the first.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Write data and byte strobes, parked in the same way as the address.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Readies are combinational. A pending write response holds both off,
    // so at most one write is under way at a time.
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

    // Register writes with byte strobes.
    // Only the control and select words take writes; the status and analog
    // words are read-only and a write to them changes nothing.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl_reg   <= CTRL_RESET;
            select_reg <= SELECT_RESET;
        end else if (do_write) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_reg[i] && awaddr_reg[7:2] == OFF_CTRL[7:2]) begin
                    ctrl_reg[8*i +: 8] <= wdata_reg[8*i +: 8];
                end
                if (wstrb_reg[i] && awaddr_reg[7:2] == OFF_SELECT[7:2]) begin
                    select_reg[8*i +: 8] <= wdata_reg[8*i +: 8];
                end
            end
        end
    end

    // Write response.
    // The response rises one cycle after both halves are parked and stands
    // until the master takes it. An unmapped or read-only offset answers
    // with a slave error.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (awaddr_reg[7:2] == OFF_CTRL[7:2] || awaddr_reg[7:2] == OFF_SELECT[7:2])
                          ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // Status snapshot: digital held bit and output, then the selected inputs.
    assign status_word = {26'h0, d_held, digital_o, a_trigger, a_enable, d_trigger, d_enable};

    // Read path: one read under way at a time.
    // The word is latched at the edge that takes the address, so it stands
    // unchanged until the master takes it. An unmapped offset reads zero.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            case (s_axi_araddr[7:2])
                OFF_CTRL[7:2]:   rdata_reg <= ctrl_reg;
                OFF_SELECT[7:2]: rdata_reg <= select_reg;
                OFF_STATUS[7:2]: rdata_reg <= status_word;
                OFF_ANALOG[7:2]: rdata_reg <= {{(32-DATA_W){1'b0}}, a_out_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Read handshake and data outputs; data and response come from flip-flops.
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

endmodule

`default_nettype wire

// ### rtl/latch_pkg.sv
package latch_pkg;

    // Data width of the analog word.
    localparam int unsigned WORD_W = 16;

    // Source select codes for trigger, enable and operand inputs.
    localparam logic [2:0] SRC_CONST   = 3'h0;
    localparam logic [2:0] SRC_ISLAND  = 3'h1;
    localparam logic [2:0] SRC_VIRTUAL = 3'h2;
    localparam logic [2:0] SRC_FIELDBUS = 3'h3;
    localparam logic [2:0] SRC_NESTED  = 3'h4;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_SELECT  = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_ANALOG  = 8'h0C;

    // Control register field positions.
    localparam int unsigned CTRL_INVERT   = 0;
    localparam int unsigned CTRL_EN_CONST = 1;
    localparam int unsigned CTRL_TRIG_CONST = 2;
    localparam int unsigned CTRL_OPER_CONST = 3;

    // Select register field positions, three bits each.
    localparam int unsigned SEL_A_EN   = 0;
    localparam int unsigned SEL_A_TRIG = 4;
    localparam int unsigned SEL_A_DATA = 8;
    localparam int unsigned SEL_D_EN   = 12;
    localparam int unsigned SEL_D_TRIG = 16;
    localparam int unsigned SEL_D_OPER = 20;

    // Reset values.
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rtl/edge_latch.sv
`timescale 1ns/100ps
`default_nettype none

// Falling-edge digital latch with enable and output inversion.
module edge_latch
    import latch_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // Block inputs.
    input  wire logic enable_i,
    input  wire logic trigger_i,
    input  wire logic operand_i,
    input  wire logic invert_i,
    // Block output.
    output logic      latch_o,
    output logic      captured_o
);

    logic trig_prev_reg;
    logic held_reg;
    logic out_reg;

    // Trigger history is kept even while disabled so inputs keep arriving.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trigger_i;
        end
    end

    // Capture the operand on a 1-to-0 trigger edge while enabled.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            held_reg <= 1'b0;
        end else if (enable_i && trig_prev_reg && !trigger_i) begin
            held_reg <= operand_i;
        end
    end

    // Output register, frozen while disabled, applies inversion when enabled.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            out_reg <= 1'b0;
        end else if (enable_i) begin
            out_reg <= (trig_prev_reg && !trigger_i ? operand_i : held_reg) ^ invert_i;
        end
    end

    assign latch_o    = out_reg;
    assign captured_o = held_reg;

endmodule

`default_nettype wire

// ### sim/reflex_latch_blocks_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Checks bus handshakes and latch outputs at the ports of the latch block.
module reflex_latch_blocks_assertions
    import latch_pkg::*;
#(
    parameter int unsigned DATA_W = WORD_W
)
(
    // Clock and reset.
    input wire logic              ref_clk_i,
    input wire logic              reset_i,
    // Register bus handshakes.
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Sources and outputs.
    input wire logic [DATA_W-1:0] island_word_i,
    input wire logic [DATA_W-1:0] virtual_word_i,
    input wire logic [DATA_W-1:0] analog_o,
    input wire logic              digital_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // Reset clears both outputs; each analog output change is tied to a source word one cycle earlier.
    AST_RESET_OUT: assert property ($fell(reset_i) |-> analog_o == '0 && !digital_o)
        else $error("outputs not cleared after reset");
    AST_ANALOG_SRC: assert property (
        $changed(analog_o) |-> analog_o == $past(island_word_i) || analog_o == $past(virtual_word_i))
        else $error("analog output not an unchanged source word");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> (!s_axi_awready && !s_axi_wready) throughout (##1 s_axi_bvalid))
        else $error("write response timing wrong");
endmodule

bind reflex_latch_blocks reflex_latch_blocks_assertions #(.DATA_W(DATA_W)) chk_i (.ref_clk_i, .reset_i,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .island_word_i,
    .virtual_word_i, .analog_o, .digital_o);
`default_nettype wire

// ### sim/island_source_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stands in for the island modules, virtual module and fieldbus master feeding the block.
module island_source_model
(
    // Clock.
    input  wire logic        ref_clk_i,
    // Boolean and analog sources.
    output logic             island_bit_o,
    output logic             virtual_bit_o,
    output logic             fieldbus_bit_o,
    output logic             nested_bit_o,
    output logic [15:0]      island_word_o,
    output logic [15:0]      virtual_word_o
);
    // Sources sit at zero until first set.
    initial begin
        {island_bit_o, virtual_bit_o, fieldbus_bit_o, nested_bit_o} = 4'h0;
        island_word_o = 16'h0;
        virtual_word_o = 16'h0;
    end

    // Presents one new evaluation sample just after a clock edge.
    task automatic put(input logic [3:0] bits, input logic [15:0] iw, input logic [15:0] vw);
        @(posedge ref_clk_i);
        {island_bit_o, virtual_bit_o, fieldbus_bit_o, nested_bit_o} <= bits;
        island_word_o <= iw;
        virtual_word_o <= vw;
    endtask
endmodule
`default_nettype wire

// ### sim/reflex_latch_blocks_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Drives the latch block through its bus and sources and judges its outputs.
module reflex_latch_blocks_tb
    import latch_pkg::*;
;
    // Clock, reset and bus.
    logic        ref_clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        island_bit_i, virtual_bit_i, fieldbus_bit_i, nested_bit_i, digital_o;
    logic [15:0] island_word_i, virtual_word_i, analog_o;
    int          failures, tests_run;

    // The far side and the block.
    island_source_model src (.ref_clk_i, .island_bit_o(island_bit_i), .virtual_bit_o(virtual_bit_i),
        .fieldbus_bit_o(fieldbus_bit_i), .nested_bit_o(nested_bit_i), .island_word_o(island_word_i),
        .virtual_word_o(virtual_word_i));
    reflex_latch_blocks uut (.ref_clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .island_bit_i, .virtual_bit_i, .fieldbus_bit_i, .nested_bit_i, .island_word_i,
        .virtual_word_i, .analog_o, .digital_o);

    // Verdict, comparison, timeout and cycle helpers.
    task automatic end_sim;
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic hang;
        failures++;
        $display("MISMATCH %0t bus timeout", $time);
        end_sim();
    endtask
    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask

    // Bus write: offer address and data together, release each once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 20) hang();
        chk(s_axi_bresp, RESP_OKAY, "write response");
    endtask

    // Bus read with comparison of data and response.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        int n;
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 20) hang();
        chk(s_axi_rdata, exp, "read data");
        chk(s_axi_rresp, resp, "read response");
    endtask

    // Reset values and an unmapped read.
    task automatic t_regs;
        chk(analog_o, 32'h0, "analog reset");
        chk(digital_o, 32'h0, "digital reset");
        rd(OFF_CTRL, CTRL_RESET, RESP_OKAY);
        rd(OFF_SELECT, SELECT_RESET, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
    endtask

    // Follow while low, capture on each rise, hold while high.
    task automatic t_analog;
        wr(OFF_SELECT, 32'h0000_0110);
        src.put(4'h0, 16'h07D0, 16'h0);
        step();
        chk(analog_o, 16'h07D0, "analog follow");
        src.put(4'h8, 16'h07D0, 16'h0);
        src.put(4'h8, 16'h0960, 16'h0);
        step();
        chk(analog_o, 16'h07D0, "analog hold");
        src.put(4'h0, 16'h8000, 16'h0);
        step();
        chk(analog_o, 16'h8000, "analog pattern");
        src.put(4'h8, 16'h0708, 16'h0);
        src.put(4'h8, 16'h0384, 16'h0);
        step();
        chk(analog_o, 16'h0708, "analog recapture");
        rd(OFF_ANALOG, 32'h0000_0708, RESP_OKAY);
        wr(OFF_SELECT, 32'h0000_0210);
        src.put(4'h0, 16'h0, 16'hFFFF);
        step();
        chk(analog_o, 16'hFFFF, "analog virtual source");
        wr(OFF_SELECT, 32'h0000_0140);
        src.put(4'h1, 16'h0ABC, 16'h0);
        src.put(4'h1, 16'h0DEF, 16'h0);
        step();
        chk(analog_o, 16'h0ABC, "nested trigger hold");
    endtask

    // Freeze while disabled, resume on the latest inputs at once.
    task automatic t_enable;
        wr(OFF_SELECT, 32'h0000_0112);
        src.put(4'h4, 16'h0384, 16'h0);
        step();
        chk(analog_o, 16'h0384, "enabled");
        src.put(4'h0, 16'h0960, 16'h0);
        step();
        step();
        chk(analog_o, 16'h0384, "frozen");
        src.put(4'h4, 16'h0960, 16'h0);
        step();
        chk(analog_o, 16'h0960, "resumed");
    endtask

    // Capture on falls only, hold between, invert, ignore edges while disabled.
    task automatic t_digital;
        wr(OFF_SELECT, 32'h0014_3000);
        src.put(4'hB, 16'h0, 16'h0);
        src.put(4'hA, 16'h0, 16'h0);
        step();
        chk(digital_o, 1'h1, "capture one");
        src.put(4'h2, 16'h0, 16'h0);
        step();
        chk(digital_o, 1'h1, "held");
        src.put(4'h3, 16'h0, 16'h0);
        src.put(4'h2, 16'h0, 16'h0);
        step();
        chk(digital_o, 1'h0, "capture zero");
        wr(OFF_CTRL, 32'h0000_0003);
        step();
        chk(digital_o, 1'h1, "inverted");
        src.put(4'h9, 16'h0, 16'h0);
        src.put(4'h8, 16'h0, 16'h0);
        step();
        chk(digital_o, 1'h1, "frozen digital");
        rd(OFF_STATUS, 32'h0000_0014, RESP_OKAY);
    endtask

    // Clock generator.
    initial begin
        ref_clk_i = 1'h0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Main sequence.
    initial begin
        reset_i = 1'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        failures = 0;
        tests_run = 0;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'h0;
        step();
        t_regs();
        t_analog();
        t_enable();
        t_digital();
        end_sim();
    end
endmodule
`default_nettype wire
